//--- design/asc_channel.v
`timescale 1ns/1ps
`include "asc_map.vh"
module asc_channel #(
  parameter DEPTH = 4
) (
  input wire clock_i,
  input wire resetn_i,
  input wire clk_en_i,
  input wire io_stop_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire rx_serial_in_i,
  input wire ext_serial_clock_i,
  input wire carrier_detect_in_n_i,
  output reg tx_serial_out_o,
  output reg rx_char_avail_o,
  output reg rx_irq_o,
  output reg rx_dma_req_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [2:0] rx_s;
  reg [2:0] ck_s;
  reg [2:0] cd_s;
  reg rx_in;
  reg ck_in;
  reg cd_n;
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      rx_s <= 3'b111;
      ck_s <= 3'b000;
      cd_s <= 3'b111;
      rx_in <= 1'b1;
      ck_in <= 1'b0;
      cd_n <= 1'b1;
    end else if (clk_en_i) begin
      rx_s <= {rx_s[1:0], rx_serial_in_i};
      ck_s <= {ck_s[1:0], ext_serial_clock_i};
      cd_s <= {cd_s[1:0], carrier_detect_in_n_i};
      if (rx_s[1] == rx_s[2])
        rx_in <= rx_s[2];
      if (ck_s[1] == ck_s[2])
        ck_in <= ck_s[2];
      if (cd_s[1] == cd_s[2])
        cd_n <= cd_s[2];
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] ctrl_word_a;
  reg [7:0] ctrl_word_b;
  reg [7:0] channel_extension;
  reg [15:0] baud_divisor;
  reg parity_fault;
  reg framing_fault;
  reg overflow_flag;
  wire acc = psel_i & penable_i & pready_o;
  wire wr = acc & pwrite_i;
  wire rd_data = acc & ~pwrite_i & (paddr_i == `ASC_RXDATA);
  wire err_clr = wr & (paddr_i == `ASC_CTRL_A) & ~pwdata_i[`ASC_A_ERRCLR];
  // Carrier only counts when auto enable is set
  wire force_idle = io_stop_i | (channel_extension[`ASC_E_DCDAUTO] & cd_n);
  wire tx_busy;
  wire fifo_empty;
  wire [7:0] head_data;
  wire [1:0] mode_sel = {channel_extension[`ASC_E_UNITY], ctrl_word_b[`ASC_B_DR]};

  // ----------------------------------------
  // Baud generator (x1/x16/x64 tick)
  // ----------------------------------------
  reg [16:0] brg_cnt;
  reg brg_tick;
  reg ck_prev;
  reg [5:0] pre_cnt;
  reg [5:0] pow_cnt;
  wire ext_mode = (ctrl_word_b[2:0] == 3'b111);
  wire [5:0] pre_max = ctrl_word_b[`ASC_B_PS] ? `ASC_PRE_HI : `ASC_PRE_LO;
  wire [5:0] pow_mask = (6'b00_0001 << ctrl_word_b[2:0]) - 6'b00_0001;
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      brg_cnt <= 17'h0_0000;
      brg_tick <= 1'b0;
      ck_prev <= 1'b0;
      pre_cnt <= 6'h00;
      pow_cnt <= 6'h00;
    end else if (clk_en_i) begin
      ck_prev <= ck_in;
      brg_tick <= 1'b0;
      if (ext_mode) begin
        brg_tick <= ck_in & ~ck_prev;
      end else if (channel_extension[`ASC_E_DIVMODE]) begin
        // Tick every 2*(divisor+2) clocks; 17 bits keep the top divisor bit
        if (brg_cnt == 17'h0_0000) begin
          brg_cnt <= {baud_divisor, 1'b0} + 17'h0_0003;
          brg_tick <= 1'b1;
        end else begin
          brg_cnt <= brg_cnt - 17'h0_0001;
        end
      end else begin
        if (pre_cnt == pre_max - 6'd1) begin
          pre_cnt <= 6'h00;
          pow_cnt <= (pow_cnt == pow_mask) ? 6'h00 : pow_cnt + 6'h01;
          if (pow_cnt == pow_mask)
            brg_tick <= 1'b1;
        end else begin
          pre_cnt <= pre_cnt + 6'h01;
        end
      end
    end
  end
  // Ticks per bit from clock mode; reserved 11 treated as 1
  reg [6:0] bit_len;
  always @* begin
    case (mode_sel)
      2'b00: bit_len = 7'd16;
      2'b01: bit_len = 7'd64;
      default: bit_len = 7'd1;
    endcase
  end

  // ----------------------------------------
  // Frame shape
  // ----------------------------------------
  wire eight_bits = ctrl_word_a[`ASC_A_FMT2];
  wire par_en = ctrl_word_b[`ASC_B_PAREN];
  wire addr_fmt = ctrl_word_a[`ASC_A_FMT1];
  wire two_stop = ctrl_word_a[`ASC_A_FMT0];
  wire [3:0] data_n = eight_bits ? 4'd8 : 4'd7;
  wire [3:0] body_n = data_n + {3'b000, par_en} + {3'b000, addr_fmt};

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_BITS = 2'd2;
  localparam RX_WAIT = 2'd3;
  reg [1:0] rx_st;
  reg [6:0] rx_tk;
  reg [3:0] rx_n;
  reg [9:0] rx_sh;
  reg rx_prev;
  reg rx_push;
  reg [2:0] rx_perr;
  reg [7:0] rx_pdata;
  reg ovf_pend;
  reg ovf_block;
  wire fifo_full;
  wire [6:0] half_len = (bit_len == 7'd1) ? 7'd1 : {1'b0, bit_len[6:1]};
  reg [7:0] fr_data;
  reg fr_par;
  reg fr_addr;
  reg fr_calc;
  always @* begin
    fr_data = eight_bits ? rx_sh[7:0] : {1'b0, rx_sh[6:0]};
    fr_par = rx_sh[data_n];
    fr_addr = par_en ? rx_sh[data_n + 4'd1] : rx_sh[data_n];
    fr_calc = ^fr_data ^ ctrl_word_b[`ASC_B_PODD];
  end
  wire stop_ok = rx_in;
  wire fr_break = ~stop_ok & (fr_data == 8'h00);
  wire fr_skip = addr_fmt & ctrl_word_a[`ASC_A_WAKE] & ~fr_addr;
  always @(posedge clock_i) begin
    if (!resetn_i || force_idle) begin
      rx_st <= RX_IDLE;
      rx_tk <= 7'd0;
      rx_n <= 4'd0;
      rx_sh <= 10'h000;
      rx_prev <= 1'b1;
      rx_push <= 1'b0;
      rx_perr <= 3'b000;
      rx_pdata <= 8'h00;
      ovf_pend <= 1'b0;
    end else if (clk_en_i) begin
      rx_push <= 1'b0;
      ovf_pend <= 1'b0;
      if (brg_tick || ext_mode) begin
        rx_prev <= rx_in;
      end
      case (rx_st)
        RX_IDLE: begin
          if (ctrl_word_a[`ASC_A_RXEN] && rx_prev && !rx_in) begin
            rx_st <= RX_START;
            rx_tk <= 7'd0;
          end
        end
        RX_START: begin
          if (brg_tick) begin
            if (rx_tk + 7'd1 >= half_len) begin
              rx_tk <= 7'd0;
              rx_n <= 4'd0;
              rx_st <= rx_in ? RX_IDLE : RX_BITS;
            end else begin
              rx_tk <= rx_tk + 7'd1;
            end
          end
        end
        RX_BITS: begin
          if (brg_tick) begin
            if (rx_tk + 7'd1 >= bit_len) begin
              rx_tk <= 7'd0;
              if (rx_n == body_n) begin
                // First stop bit sampled: queue now, in the stop bit
                rx_st <= fr_break ? RX_WAIT : RX_IDLE;
                if (!fr_skip) begin
                  if (fifo_full || ovf_block) begin
                    ovf_pend <= fifo_full & ~ovf_block;
                  end else begin
                    rx_push <= 1'b1;
                    rx_pdata <= fr_data;
                    rx_perr <= {1'b0, ~stop_ok, par_en & (fr_par != fr_calc)};
                  end
                end
              end else begin
                rx_sh[rx_n] <= rx_in;
                rx_n <= rx_n + 4'd1;
              end
            end else begin
              rx_tk <= rx_tk + 7'd1;
            end
          end
        end
        default: begin
          if (rx_in)
            rx_st <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Data and error FIFOs
  // ----------------------------------------
  reg [7:0] fifo_d [0:DEPTH-1];
  reg [2:0] fifo_e [0:DEPTH-1];
  reg [2:0] rd_ptr;
  reg [2:0] wr_ptr;
  reg [2:0] count;
  reg head_seen;
  assign fifo_empty = (count == 3'd0);
  assign fifo_full = (count == DEPTH);
  assign head_data = fifo_d[rd_ptr[1:0]];
  wire pop = rd_data & ~fifo_empty;
  wire [1:0] last_ix = wr_ptr[1:0] - 2'd1;
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
      always @(posedge clock_i) begin
        if (!resetn_i || force_idle) begin
          fifo_d[gi] <= 8'h00;
          fifo_e[gi] <= 3'b000;
        end else if (clk_en_i) begin
          if (rx_push && wr_ptr[1:0] == gi) begin
            fifo_d[gi] <= rx_pdata;
            fifo_e[gi] <= rx_perr;
          end else if (ovf_pend && last_ix == gi) begin
            fifo_e[gi] <= fifo_e[gi] | 3'b100;
          end
        end
      end
    end
  endgenerate
  always @(posedge clock_i) begin
    if (!resetn_i || force_idle) begin
      rd_ptr <= 3'd0;
      wr_ptr <= 3'd0;
      count <= 3'd0;
      head_seen <= 1'b0;
      ovf_block <= 1'b0;
    end else if (clk_en_i) begin
      if (rx_push)
        wr_ptr <= wr_ptr + 3'd1;
      if (pop)
        rd_ptr <= rd_ptr + 3'd1;
      count <= count + {2'b00, rx_push} - {2'b00, pop};
      head_seen <= ~fifo_empty & ~pop;
      if (ovf_pend)
        ovf_block <= 1'b1;
      else if (err_clr && overflow_flag)
        ovf_block <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sticky error latches, register writes
  // ----------------------------------------
  wire [2:0] head_err = fifo_empty ? 3'b000 : fifo_e[rd_ptr[1:0]];
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      ctrl_word_a <= `ASC_CTRLA_RST;
      ctrl_word_b <= `ASC_CTRLB_RST;
      channel_extension <= `ASC_EXT_RST;
      baud_divisor <= `ASC_DIV_RST;
      parity_fault <= 1'b0;
      framing_fault <= 1'b0;
      overflow_flag <= 1'b0;
    end else if (clk_en_i) begin
      if (wr && paddr_i == `ASC_CTRL_A)
        ctrl_word_a <= {pwdata_i[7:4], 1'b1, pwdata_i[2:0]};
      if (wr && paddr_i == `ASC_CTRL_B)
        ctrl_word_b <= pwdata_i[7:0];
      if (wr && paddr_i == `ASC_EXT)
        channel_extension <= pwdata_i[7:0];
      if (wr && paddr_i == `ASC_DIV)
        baud_divisor <= pwdata_i[15:0];
      // Set wins over the clear in the same cycle
      parity_fault <= (parity_fault & ~err_clr) | head_err[0];
      framing_fault <= (framing_fault & ~err_clr) | head_err[1];
      overflow_flag <= (overflow_flag & ~err_clr) | head_err[2];
      if (force_idle) begin
        ctrl_word_a[`ASC_A_RXEN] <= 1'b0;
        ctrl_word_a[`ASC_A_TXEN] <= 1'b0;
        parity_fault <= 1'b0;
        framing_fault <= 1'b0;
        overflow_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  reg [11:0] tx_sh;
  reg [3:0] tx_left;
  reg [6:0] tx_tk;
  reg tx_go;
  assign tx_busy = (tx_left != 4'd0);
  wire tx_load = wr & (paddr_i == `ASC_TXDATA) & ~tx_busy & ctrl_word_a[`ASC_A_TXEN];
  wire [7:0] tx_d = eight_bits ? pwdata_i[7:0] : {1'b0, pwdata_i[6:0]};
  wire tx_pb = ^tx_d ^ ctrl_word_b[`ASC_B_PODD];
  reg [11:0] tx_frame;
  always @* begin
    tx_frame = 12'hFFF;
    tx_frame[8:1] = tx_d;
    tx_frame[0] = 1'b0;
    if (!eight_bits)
      tx_frame[8] = 1'b1;
    if (par_en)
      tx_frame[data_n + 4'd1] = tx_pb;
    if (addr_fmt)
      tx_frame[body_n] = ctrl_word_b[`ASC_B_ADDRB];
  end
  always @(posedge clock_i) begin
    if (!resetn_i || force_idle) begin
      tx_sh <= 12'hFFF;
      tx_left <= 4'd0;
      tx_tk <= 7'd0;
      tx_go <= 1'b0;
      tx_serial_out_o <= 1'b1;
    end else if (clk_en_i) begin
      if (tx_load) begin
        tx_sh <= tx_frame;
        tx_left <= body_n + 4'd2 + {3'b000, two_stop};
        tx_tk <= 7'd0;
        tx_go <= 1'b0;
      end else if (tx_busy && brg_tick) begin
        // Start on a tick, else the start bit comes out short
        if (!tx_go) begin
          tx_go <= 1'b1;
        end else if (tx_tk + 7'd1 >= bit_len) begin
          tx_tk <= 7'd0;
          tx_sh <= {1'b1, tx_sh[11:1]};
          tx_left <= tx_left - 4'd1;
        end else begin
          tx_tk <= tx_tk + 7'd1;
        end
      end
      tx_serial_out_o <= (tx_busy && tx_go) ? tx_sh[0] : 1'b1;
    end
  end

  // ----------------------------------------
  // Request outputs, APB read path
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      rx_char_avail_o <= 1'b0;
      rx_irq_o <= 1'b0;
      rx_dma_req_o <= 1'b0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      // Drops for two cycles on a pop, then returns if more queued
      rx_char_avail_o <= ~fifo_empty & ~pop & head_seen;
      rx_irq_o <= ~fifo_empty & ~pop & head_seen;
      rx_dma_req_o <= ~fifo_empty & ~pop & head_seen
                      & ~(parity_fault | framing_fault | overflow_flag);
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & (paddr_i > `ASC_TXDATA);
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i) begin
        case (paddr_i)
          `ASC_CTRL_A: prdata_o <= {24'h00_0000, ctrl_word_a};
          `ASC_CTRL_B: prdata_o <= {24'h00_0000, ctrl_word_b};
          `ASC_EXT: prdata_o <= {24'h00_0000, channel_extension};
          `ASC_DIV: prdata_o <= {16'h0000, baud_divisor};
          `ASC_RXDATA: prdata_o <= {24'h00_0000, head_data};
          `ASC_STATUS: prdata_o <= {27'h000_0000, tx_busy, overflow_flag,
                                     framing_fault, parity_fault, ~fifo_empty};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

//--- design/asc_map.vh
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
// Register byte offsets
`define ASC_CTRL_A 12'h000
`define ASC_CTRL_B 12'h004
`define ASC_EXT 12'h008
`define ASC_DIV 12'h00C
`define ASC_RXDATA 12'h010
`define ASC_STATUS 12'h014
`define ASC_TXDATA 12'h018
// Control word A fields
`define ASC_A_FMT0 0
`define ASC_A_FMT1 1
`define ASC_A_FMT2 2
`define ASC_A_ERRCLR 3
`define ASC_A_WAKE 4
`define ASC_A_TXEN 5
`define ASC_A_RXEN 6
// Control word B fields
`define ASC_B_DR 3
`define ASC_B_PAREN 4
`define ASC_B_PS 5
`define ASC_B_PODD 6
`define ASC_B_ADDRB 7
// Extension fields
`define ASC_E_DIVMODE 3
`define ASC_E_UNITY 4
`define ASC_E_DCDAUTO 5
// Status fields
`define ASC_S_AVAIL 0
`define ASC_S_PAR 1
`define ASC_S_FRM 2
`define ASC_S_OVF 3
`define ASC_S_TXBUSY 4
// Reset values
`define ASC_CTRLA_RST 8'h08
`define ASC_CTRLB_RST 8'h07
`define ASC_EXT_RST 8'h00
`define ASC_DIV_RST 16'h0000
// Fixed prescale steps
`define ASC_PRE_LO 6'd10
`define ASC_PRE_HI 6'd30
`endif

//--- sim/asc_channel_checker.sv
`timescale 1ns/1ps
`include "asc_map.vh"
module asc_channel_checker #(
  parameter DEPTH = 4
) (
  input wire clock_i,
  input wire resetn_i,
  input wire io_stop_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire carrier_detect_in_n_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire tx_serial_out_o,
  input wire rx_char_avail_o,
  input wire rx_irq_o,
  input wire rx_dma_req_o
);
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire rd_pop = psel_i && penable_i && pready_o && !pwrite_i && paddr_i == `ASC_RXDATA;
  // Carrier only flushes with auto enable, so this is deliberately loose
  wire flush = io_stop_i || carrier_detect_in_n_i;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_irq_follows: assert property (rx_irq_o == rx_char_avail_o)
    else $error("irq differs from avail");
  chk_dma_data: assert property (rx_dma_req_o |-> rx_char_avail_o)
    else $error("dma request without data");
  chk_avail_holds: assert property ($fell(rx_char_avail_o) |->
    $past(rd_pop) || $past(rd_pop, 2) || $past(rd_pop, 3) || $past(flush) || $past(flush, 2))
    else $error("avail dropped without a read");
  chk_stop_empty: assert property (io_stop_i [*3] |-> !rx_char_avail_o && !rx_dma_req_o)
    else $error("stop left data pending");
  chk_stop_tx_idle: assert property (io_stop_i [*3] |-> tx_serial_out_o)
    else $error("tx not idle in stop");
  chk_tx_start_low: assert property ($fell(tx_serial_out_o) |=> !tx_serial_out_o)
    else $error("start bit too short");
  chk_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no answer after setup");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  chk_slverr_map: assert property (pready_o |-> pslverr_o == (paddr_i > `ASC_TXDATA))
    else $error("pslverr wrong for address");
  cov_avail: cover property ($rose(rx_char_avail_o));
  cov_dma: cover property ($rose(rx_dma_req_o));
  cov_slverr: cover property (pready_o && pslverr_o);
endmodule

bind asc_channel asc_channel_checker #(.DEPTH(DEPTH)) u_chk (.clock_i(clock_i),
  .resetn_i(resetn_i), .io_stop_i(io_stop_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .carrier_detect_in_n_i(carrier_detect_in_n_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_serial_out_o(tx_serial_out_o),
  .rx_char_avail_o(rx_char_avail_o), .rx_irq_o(rx_irq_o), .rx_dma_req_o(rx_dma_req_o));

//--- sim/asc_remote.sv
`timescale 1ns/1ps
module asc_remote #(
  parameter BIT = 64
) (
  input wire clock_i,
  input wire tx_line_i,
  output reg rx_line_o
);
  reg [7:0] got;
  reg got_stop;
  integer n_got;
  integer j;
  initial begin
    rx_line_o = 1'b1;
    n_got = 0;
  end
  task automatic bit_out(input logic b, input integer n);
    rx_line_o <= b;
    repeat (n) @(posedge clock_i);
  endtask
  // A low stop holds the line low for eight bits, which is how a break looks
  task automatic send(input logic [7:0] d, input logic mp_en, input logic mp, input logic stp);
    integer k;
    bit_out(1'b0, BIT);
    for (k = 0; k < 8; k++) begin
      bit_out(d[k], BIT);
    end
    if (mp_en) begin
      bit_out(mp, BIT);
    end
    bit_out(stp, stp ? BIT : 8 * BIT);
    bit_out(1'b1, 2 * BIT);
  endtask
  task automatic glitch;
    // Long enough to pass the pin filter, shorter than half a bit
    bit_out(1'b0, BIT / 8);
    bit_out(1'b1, 2 * BIT);
  endtask
  // Samples mid-bit only at BIT clocks per bit; frames at other rates decode as junk
  initial forever begin
    @(negedge tx_line_i);
    repeat (BIT / 2) @(posedge clock_i);
    for (j = 0; j < 8; j++) begin
      repeat (BIT) @(posedge clock_i);
      got[j] = tx_line_i;
    end
    repeat (BIT) @(posedge clock_i);
    got_stop = tx_line_i;
    n_got = n_got + 1;
  end
endmodule

//--- sim/asc_channel_tb.sv
`timescale 1ns/1ps
`include "asc_map.vh"
module asc_channel_tb;
  logic clock_i = 0;
  logic resetn_i = 0;
  logic io_stop = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic ext_clk = 0;
  logic dcd_n = 0;
  logic err;
  logic [7:0] b;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] rdata;
  logic [7:0] q [$];
  logic [31:0] cfg [5] = '{32'h1800_0106, 32'h1000_000A, 32'h1021_003C, 32'h0800_0040,
    32'h1007_0006};
  wire [31:0] prdata;
  wire pready, pslverr, tx, rx, avail, irq, dma;
  integer failures = 0;
  integer n_checks = 0;
  integer k, n;
  asc_channel u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
    .io_stop_i(io_stop), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rx_serial_in_i(rx), .ext_serial_clock_i(ext_clk),
    .carrier_detect_in_n_i(dcd_n), .tx_serial_out_o(tx), .rx_char_avail_o(avail),
    .rx_irq_o(irq), .rx_dma_req_o(dma));
  asc_remote u_peer (.clock_i(clock_i), .tx_line_i(tx), .rx_line_o(rx));
  initial forever #50 clock_i = ~clock_i;
  // External serial clock: one rising edge every six system clocks
  initial forever begin
    repeat (3) @(posedge clock_i);
    ext_clk <= ~ext_clk;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One idle cycle after each transfer keeps drivers from double assignment
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clock_i);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) check("pready", 1, 0);
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
    apb(1'b0, a, 32'h0);
    check(what, e, rdata);
  endtask
  task automatic final_report;
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock_i);
    failures++;
    final_report;
  end
  initial begin
    void'($urandom(32'hd521));
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(`ASC_CTRL_A, `ASC_CTRLA_RST, "ctrl_a reset");
    rd(`ASC_CTRL_B, `ASC_CTRLB_RST, "ctrl_b reset");
    rd(`ASC_EXT, `ASC_EXT_RST, "ext reset");
    rd(`ASC_STATUS, 32'h0, "status reset");
    rd(12'h01C, 32'h0, "unmapped read");
    check("unmapped error", 1, err);
    // Sixteen ticks of four clocks per bit: x1 has no margin for an unaligned line
    wr(`ASC_EXT, 32'h08);
    wr(`ASC_DIV, 32'h0);
    wr(`ASC_CTRL_B, 32'h0);
    wr(`ASC_CTRL_A, 32'h6C);
    // Four fill the FIFO, the last two overrun
    for (k = 0; k < 6; k++) begin
      q.push_back(8'($urandom));
      u_peer.send(q[k], 1'b0, 1'b0, 1'b1);
    end
    check("irq full", 1, irq);
    check("dma full", 1, dma);
    for (k = 0; k < 4; k++) begin
      rd(`ASC_RXDATA, q[k], "fifo data");
    end
    rd(`ASC_STATUS, 32'h08, "overrun latch");
    u_peer.send(8'h3C, 1'b0, 1'b0, 1'b1);
    rd(`ASC_STATUS, 32'h08, "dropped after overrun");
    wr(`ASC_CTRL_A, 32'h64);
    u_peer.send(8'hC3, 1'b0, 1'b0, 1'b1);
    rd(`ASC_STATUS, 32'h01, "cleared and queued");
    rd(`ASC_RXDATA, 32'hC3, "data after clear");
    u_peer.send(8'h5A, 1'b0, 1'b0, 1'b0);
    u_peer.send(8'h33, 1'b0, 1'b0, 1'b1);
    check("dma held off", 0, dma);
    rd(`ASC_STATUS, 32'h05, "framing latch");
    rd(`ASC_RXDATA, 32'h5A, "framed byte");
    rd(`ASC_RXDATA, 32'h33, "next byte");
    wr(`ASC_CTRL_A, 32'h64);
    u_peer.send(8'h00, 1'b0, 1'b0, 1'b0);
    u_peer.send(8'h81, 1'b0, 1'b0, 1'b1);
    rd(`ASC_RXDATA, 32'h00, "break byte");
    rd(`ASC_STATUS, 32'h05, "break latch");
    rd(`ASC_RXDATA, 32'h81, "after break");
    wr(`ASC_CTRL_A, 32'h74);
    wr(`ASC_CTRL_A, 32'h7E);
    u_peer.send(8'h11, 1'b1, 1'b0, 1'b1);
    u_peer.send(8'h22, 1'b1, 1'b1, 1'b1);
    u_peer.glitch;
    rd(`ASC_RXDATA, 32'h22, "address frame");
    rd(`ASC_STATUS, 32'h0, "filtered and noise");
    wr(`ASC_CTRL_B, 32'h10);
    wr(`ASC_CTRL_A, 32'h68);
    u_peer.send(8'h01, 1'b0, 1'b0, 1'b1);
    u_peer.send(8'h81, 1'b0, 1'b0, 1'b1);
    check("dma parity", 0, dma);
    rd(`ASC_STATUS, 32'h03, "parity latch");
    rd(`ASC_RXDATA, 32'h01, "parity byte");
    rd(`ASC_RXDATA, 32'h01, "good parity");
    wr(`ASC_CTRL_B, 32'h0);
    wr(`ASC_CTRL_A, 32'h64);
    wr(`ASC_CTRL_A, 32'h6C);
    k = u_peer.n_got;
    b = 8'($urandom);
    wr(`ASC_TXDATA, {24'h0, b});
    repeat (700) @(posedge clock_i);
    check("tx byte", b, u_peer.got);
    check("tx stop", 1, u_peer.got_stop);
    check("tx frames", k + 1, u_peer.n_got);
    u_peer.send(8'h44, 1'b0, 1'b0, 1'b1);
    dcd_n <= 1'b1;
    repeat (5) @(posedge clock_i);
    rd(`ASC_CTRL_A, 32'h6C, "carrier ignored");
    check("carrier data kept", 1, avail);
    wr(`ASC_EXT, 32'h28);
    rd(`ASC_CTRL_A, 32'h0C, "carrier idle");
    check("carrier flush", 0, avail);
    dcd_n <= 1'b0;
    wr(`ASC_EXT, 32'h08);
    wr(`ASC_CTRL_A, 32'h6C);
    u_peer.send(8'h55, 1'b0, 1'b0, 1'b1);
    io_stop <= 1'b1;
    repeat (4) @(posedge clock_i);
    io_stop <= 1'b0;
    rd(`ASC_CTRL_A, 32'h0C, "stop idle");
    rd(`ASC_STATUS, 32'h0, "stop flush");
    wr(`ASC_CTRL_A, 32'h6C);
    // Start bit width of an all-ones byte gives the bit period
    for (k = 0; k < 5; k++) begin
      wr(`ASC_EXT, {24'h0, cfg[k][31:24]});
      wr(`ASC_CTRL_B, {24'h0, cfg[k][23:16]});
      wr(`ASC_DIV, {24'h0, cfg[k][15:8]});
      wr(`ASC_TXDATA, 32'hFF);
      n = 0;
      while (tx === 1'b1 && n < 300) begin
        @(posedge clock_i);
        n++;
      end
      n = 0;
      while (tx === 1'b0 && n < 300) begin
        @(posedge clock_i);
        n++;
      end
      check("bit period", cfg[k][7:0], n);
      repeat (12 * cfg[k][7:0]) @(posedge clock_i);
    end
    final_report;
  end
endmodule
